// ==== hdl/led_flash_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef LED_FLASH_REGS_SVH
`define LED_FLASH_REGS_SVH
// ****************************************
// Byte offsets
// ****************************************
`define OFS_PIN_SEL 8'h00
`define OFS_SEQ_EN 8'h04
`define OFS_RAMP 8'h08
`define OFS_CH_A 8'h0C
`define OFS_CH_B 8'h10
`define OFS_CH_C 8'h14
`define OFS_SLOT 8'h18
`define OFS_STATUS 8'h1C
// ****************************************
// Field positions
// ****************************************
`define SEQ_FLASH_LSB 4
`define RAMP_DOWN_LSB 8
`define CH_DUTY_LSB 4
`define CH_RAMP_BIT 9
`define CH_ON_LSB 16
// ****************************************
// Reset values and codes
// ****************************************
`define CH_RESET 32'h0000_0004
`define SLOT_RESET 8'h20
`define DUTY_FULL 5'h1F
// ****************************************
// Timing
// ****************************************
`define RAMP_STEP_MS 8
`define CLK_MHZ 125
`define STEP_CYCLES (`RAMP_STEP_MS * 1000 * `CLK_MHZ)
`endif

// ==== hdl/led_flash_pkg.sv ====
// Types shared by the LED flash sequencer
package led_flash_pkg;
    // Sequencer phase within a slot
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_UP = 3'b001,
        PH_ON = 3'b010,
        PH_DOWN = 3'b011,
        PH_GAP = 3'b100
    } phase_t;
    // Channel settings
    typedef struct packed {
        logic [7:0] on_dur;
        logic ramp_sel;
        logic [4:0] duty;
        logic [3:0] code;
    } chan_cfg_t;
    // Sink drive towards one pin
    typedef struct packed {
        logic led_mode;
        logic sink_on;
        logic [3:0] level;
    } sink_t;
endpackage

// ==== hdl/led_flash_sequencer.sv ====
// Three-channel LED current-sink controller with flash sequencer
`timescale 1ns/1ps
`include "led_flash_regs.svh"
// Behaviour
// R1 - Select bit hands pin to LED sink
// R2 - Sink current is PWM by 5-bit duty
// R3 - Duty all ones conducts continuously
// R4 - Software configures all three pins alike
// R5 - Four-bit code sets 2 to 20 mA
// R6 - Sink conducts only while enable set
// R7 - Flash enable starts channel's own sequencer
// R8 - Cycle of slots T1-T4, TP with ramps
// R9 - Ramp step code 0-31 times 8 ms
// R10 - Ramp slopes shared, rest per channel; slot length here is one register shared by all channels
// R11 - Ramp select: jump or step to level
// R12 - Ramps plus on-time shorter than slot
// R13 - Cycle repeats while flash enable stays
module led_flash_sequencer #(
    parameter int STEP_CYC = `STEP_CYCLES, // Cycles per 8 ms step
    parameter int NCH = 3 // Channel count
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    output led_flash_pkg::sink_t [NCH-1:0] sink_o,
    output logic [NCH-1:0] pwm_o
);
    // ****************************************
    // Bus slave
    // ****************************************
    logic ack_r, ack_nxt; // High in the completing cycle
    logic [31:0] rdata_r, rdata_nxt; // Read data
    logic [NCH-1:0] sel_r, sel_nxt; // LED mode per pin
    logic [NCH-1:0] sink_en_r, sink_en_nxt; // Sink enables
    logic [NCH-1:0] flash_r, flash_nxt; // Flash enables
    logic [4:0] rup_r, rup_nxt; // Shared ramp-up code
    logic [4:0] rdn_r, rdn_nxt; // Shared ramp-down code
    logic [7:0] slot_r, slot_nxt; // Slot length in steps
    led_flash_pkg::chan_cfg_t [NCH-1:0] cfg_r, cfg_nxt; // Per channel
    led_flash_pkg::phase_t [NCH-1:0] ph_r, ph_nxt; // Phases
    logic [NCH-1:0][2:0] slot_idx_r, slot_idx_nxt; // Slot 0..4
    logic [NCH-1:0][3:0] lvl_r, lvl_nxt; // Current level
    logic [NCH-1:0][7:0] t_r, t_nxt; // Steps inside slot
    logic [NCH-1:0][7:0] on_r, on_nxt; // Steps in on phase
    logic [NCH-1:0][4:0] rs_r, rs_nxt; // Steps toward next ramp move
    logic [31:0] pre_r, pre_nxt; // Step prescaler
    logic [4:0] pwm_cnt_r, pwm_cnt_nxt; // PWM phase 0..30
    logic tick; // One-cycle step pulse
    logic acc; // Access completes now
    logic [31:0] rd_val; // Decoded read value

    // Channel config to register image
    function automatic logic [31:0] cfg_word(input led_flash_pkg::chan_cfg_t c);
        cfg_word = {8'h00, c.on_dur, 6'h00, c.ramp_sel, c.duty, c.code};
    endfunction

    // Register image to channel config
    function automatic led_flash_pkg::chan_cfg_t word_cfg(input logic [31:0] w);
        word_cfg.on_dur = w[`CH_ON_LSB +: 8];
        word_cfg.ramp_sel = w[`CH_RAMP_BIT];
        word_cfg.duty = w[`CH_DUTY_LSB +: 5];
        word_cfg.code = w[3:0];
    endfunction

    // One wait state on every access
    assign waitrequest_o = (read_i | write_i) & ~ack_r;
    assign acc = (read_i | write_i) & ack_r;
    assign readdata_o = rdata_r;

    // Read decode; unmapped words read zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (address_i)
            `OFS_PIN_SEL: rd_val = {29'h0, sel_r};
            `OFS_SEQ_EN: rd_val = {25'h0, flash_r, 1'b0, sink_en_r};
            `OFS_RAMP: rd_val = {19'h0, rdn_r, 3'h0, rup_r};
            `OFS_CH_A: rd_val = cfg_word(cfg_r[0]);
            `OFS_CH_B: rd_val = cfg_word(cfg_r[1]);
            `OFS_CH_C: rd_val = cfg_word(cfg_r[2]);
            `OFS_SLOT: rd_val = {24'h0, slot_r};
            // Live state: phase, slot and level per channel
            `OFS_STATUS: rd_val = {2'h0, ph_r[2], slot_idx_r[2], lvl_r[2],
                ph_r[1], slot_idx_r[1], lvl_r[1], ph_r[0], slot_idx_r[0], lvl_r[0]};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Register writes and bus handshake
    always_comb
    begin
        ack_nxt = (read_i | write_i) & ~ack_r;
        rdata_nxt = (read_i && !ack_r) ? rd_val : rdata_r; // Load once, then hold
        sel_nxt = sel_r;
        sink_en_nxt = sink_en_r;
        flash_nxt = flash_r;
        rup_nxt = rup_r;
        rdn_nxt = rdn_r;
        slot_nxt = slot_r;
        cfg_nxt = cfg_r;
        if (write_i && ack_r)
        begin
            case (address_i)
                `OFS_PIN_SEL: sel_nxt = writedata_i[2:0]; // [R1] [R4]
                `OFS_SEQ_EN:
                begin
                    sink_en_nxt = writedata_i[2:0];
                    flash_nxt = writedata_i[`SEQ_FLASH_LSB +: 3];
                end
                `OFS_RAMP:
                begin
                    rup_nxt = writedata_i[4:0]; // [R9] [R10]
                    rdn_nxt = writedata_i[`RAMP_DOWN_LSB +: 5];
                end
                `OFS_CH_A: cfg_nxt[0] = word_cfg(writedata_i); // [R10]
                `OFS_CH_B: cfg_nxt[1] = word_cfg(writedata_i);
                `OFS_CH_C: cfg_nxt[2] = word_cfg(writedata_i);
                `OFS_SLOT: slot_nxt = writedata_i[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            sel_r <= 3'h0;
            sink_en_r <= 3'h0;
            flash_r <= 3'h0;
            rup_r <= 5'h00;
            rdn_r <= 5'h00;
            slot_r <= `SLOT_RESET;
            cfg_r <= {NCH{word_cfg(`CH_RESET)}};
        end
        else
        begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            sel_r <= sel_nxt;
            sink_en_r <= sink_en_nxt;
            flash_r <= flash_nxt;
            rup_r <= rup_nxt;
            rdn_r <= rdn_nxt;
            slot_r <= slot_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    // ****************************************
    // Step timebase and PWM
    // ****************************************
    assign tick = (pre_r == 32'(STEP_CYC - 1));

    // Prescaler and PWM phase counter
    always_comb
    begin
        pre_nxt = tick ? 32'h0 : pre_r + 32'h1;
        pwm_cnt_nxt = (pwm_cnt_r == 5'h1E) ? 5'h00 : pwm_cnt_r + 5'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pre_r <= 32'h0;
            pwm_cnt_r <= 5'h00;
        end
        else
        begin
            pre_r <= pre_nxt;
            pwm_cnt_r <= pwm_cnt_nxt;
        end
    end

    // ****************************************
    // Flash sequencer per channel
    // ****************************************
    always_comb
    begin
        ph_nxt = ph_r;
        slot_idx_nxt = slot_idx_r;
        lvl_nxt = lvl_r;
        t_nxt = t_r;
        on_nxt = on_r;
        rs_nxt = rs_r;
        for (int i = 0; i < NCH; i++)
        begin
            if (!flash_r[i])
            begin
                // Steady mode: sequencer stops and level returns to the code
                ph_nxt[i] = led_flash_pkg::PH_IDLE; // [R13]
                slot_idx_nxt[i] = 3'h0;
                t_nxt[i] = 8'h00;
                on_nxt[i] = 8'h00;
                rs_nxt[i] = 5'h00;
                lvl_nxt[i] = cfg_r[i].code; // [R5]
            end
            else if (tick)
            begin
                t_nxt[i] = t_r[i] + 8'h01;
                case (ph_r[i])
                    // Start of cycle from T1
                    led_flash_pkg::PH_IDLE:
                    begin
                        ph_nxt[i] = led_flash_pkg::PH_UP; // [R7]
                        slot_idx_nxt[i] = 3'h0;
                        t_nxt[i] = 8'h00;
                        rs_nxt[i] = 5'h00;
                        lvl_nxt[i] = 4'h0;
                    end
                    // Ramp or jump up to level
                    led_flash_pkg::PH_UP:
                    begin
                        if (!cfg_r[i].ramp_sel || rup_r == 5'h00 || lvl_r[i] >= cfg_r[i].code)
                        begin
                            lvl_nxt[i] = cfg_r[i].code; // [R11]
                            ph_nxt[i] = led_flash_pkg::PH_ON;
                            on_nxt[i] = 8'h00;
                        end
                        else if (rs_r[i] + 5'h01 >= rup_r)
                        begin
                            lvl_nxt[i] = lvl_r[i] + 4'h1; // [R9] [R11]
                            rs_nxt[i] = 5'h00;
                        end
                        else
                            rs_nxt[i] = rs_r[i] + 5'h01;
                    end
                    // Hold on-time at level
                    led_flash_pkg::PH_ON:
                    begin
                        on_nxt[i] = on_r[i] + 8'h01;
                        if (on_r[i] + 8'h01 >= cfg_r[i].on_dur)
                        begin
                            ph_nxt[i] = led_flash_pkg::PH_DOWN; // [R8]
                            rs_nxt[i] = 5'h00;
                        end
                    end
                    // Ramp or jump down to off
                    led_flash_pkg::PH_DOWN:
                    begin
                        if (!cfg_r[i].ramp_sel || rdn_r == 5'h00 || lvl_r[i] == 4'h0)
                        begin
                            lvl_nxt[i] = 4'h0; // [R11]
                            ph_nxt[i] = led_flash_pkg::PH_GAP;
                        end
                        else if (rs_r[i] + 5'h01 >= rdn_r)
                        begin
                            lvl_nxt[i] = lvl_r[i] - 4'h1;
                            rs_nxt[i] = 5'h00;
                        end
                        else
                            rs_nxt[i] = rs_r[i] + 5'h01;
                    end
                    // Off until slot ends, then next slot
                    led_flash_pkg::PH_GAP:
                    begin
                        if (t_r[i] + 8'h01 >= slot_r) // [R12]
                        begin
                            t_nxt[i] = 8'h00;
                            rs_nxt[i] = 5'h00;
                            ph_nxt[i] = led_flash_pkg::PH_UP; // [R8]
                            slot_idx_nxt[i] = (slot_idx_r[i] == 3'h4) ? 3'h0
                                : slot_idx_r[i] + 3'h1; // [R13]
                        end
                    end
                    default: ph_nxt[i] = led_flash_pkg::PH_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ph_r <= {NCH{led_flash_pkg::PH_IDLE}};
            slot_idx_r <= '0;
            lvl_r <= '0;
            t_r <= '0;
            on_r <= '0;
            rs_r <= '0;
        end
        else
        begin
            ph_r <= ph_nxt;
            slot_idx_r <= slot_idx_nxt;
            lvl_r <= lvl_nxt;
            t_r <= t_nxt;
            on_r <= on_nxt;
            rs_r <= rs_nxt;
        end
    end

    // ****************************************
    // Sink outputs
    // ****************************************
    led_flash_pkg::sink_t [NCH-1:0] sink_r, sink_nxt; // Drive image
    logic [NCH-1:0] pwm_r, pwm_nxt; // Gated PWM state

    // Pin mode, enable and PWM gating
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            sink_nxt[i].led_mode = sel_r[i]; // [R1]
            sink_nxt[i].level = lvl_r[i]; // [R5]
            sink_nxt[i].sink_on = sel_r[i] & sink_en_r[i] & (lvl_r[i] != 4'h0); // [R6]
            pwm_nxt[i] = sink_nxt[i].sink_on & ((cfg_r[i].duty == `DUTY_FULL) // [R3]
                | (pwm_cnt_r < cfg_r[i].duty)); // [R2]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sink_r <= '0;
            pwm_r <= '0;
        end
        else
        begin
            sink_r <= sink_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign sink_o = sink_r;
    assign pwm_o = pwm_r;
endmodule // led_flash_sequencer

// ==== dv/led_flash_sequencer_monitor.sv ====
// Port checker for the LED flash sequencer
`timescale 1ns/1ps
// ****
// Checker
// ****
module led_flash_sequencer_monitor #(
    parameter int NCH = 3 // Channel count
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    input wire led_flash_pkg::sink_t [NCH-1:0] sink_o,
    input wire logic [NCH-1:0] pwm_o
);
    logic [NCH-1:0] mode_v; // Pin in LED mode
    logic [NCH-1:0] on_v; // Sink conducting
    logic [NCH-1:0] zero_v; // Level code zero
    logic req; // Any bus request
    // Split the sink structs into vectors
    always_comb
    begin
        for (int k = 0; k < NCH; k++)
        begin
            mode_v[k] = sink_o[k].led_mode;
            on_v[k] = sink_o[k].sink_on;
            zero_v[k] = (sink_o[k].level == 4'h0);
        end
    end
    assign req = read_i | write_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Access steps
    sequence s_wait; req && waitrequest_o; endsequence
    sequence s_done; read_i && !waitrequest_o; endsequence
    mode_gate_a: assert property ((on_v & ~mode_v) == '0)
        else $error("sink on outside LED mode");
    pwm_gate_a: assert property ((pwm_o & ~on_v) == '0)
        else $error("pwm active with sink off");
    level_on_a: assert property ((on_v & zero_v) == '0)
        else $error("sink on at level zero");
    reset_off_a: assert property ($past(rst_i) |-> on_v == '0 && mode_v == '0 && pwm_o == '0)
        else $error("outputs not idle after reset");
    wait_first_a: assert property ($rose(req) |-> waitrequest_o)
        else $error("no wait state on new access");
    wait_one_a: assert property (s_wait ##1 req |-> !waitrequest_o)
        else $error("access not answered after one wait");
    idle_nowait_a: assert property (!req |-> !waitrequest_o)
        else $error("wait raised without request");
    rdata_hold_a: assert property ($changed(readdata_o) |-> s_done)
        else $error("read data moved outside a read");
endmodule // led_flash_sequencer_monitor

bind led_flash_sequencer led_flash_sequencer_monitor #(.NCH(NCH)) led_flash_sequencer_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .sink_o(sink_o), .pwm_o(pwm_o));

// ==== dv/led_load_model.sv ====
// External LEDs hanging on the three sink pins
`timescale 1ns/1ps
// ****
// LED load
// ****
module led_load_model (
    input wire logic clk_i,
    input wire led_flash_pkg::sink_t [2:0] sink_i,
    input wire logic [2:0] pwm_i,
    output int lit_o [3]
);
    initial lit_o = '{0, 0, 0};
    // Count cycles each LED really carries current
    always @(posedge clk_i)
    begin
        for (int k = 0; k < 3; k++)
        begin
            if (sink_i[k].led_mode && sink_i[k].sink_on && pwm_i[k] && sink_i[k].level != 4'h0)
                lit_o[k] <= lit_o[k] + 1;
        end
    end
endmodule // led_load_model

// ==== dv/led_flash_sequencer_tb.sv ====
// Self-checking bench for the LED flash sequencer
`timescale 1ns/1ps
`include "led_flash_regs.svh"
// ****
// Bench
// ****
module led_flash_sequencer_tb;
    localparam int STEP = 4; // Cycles per ramp step
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] address_i = 8'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    led_flash_pkg::sink_t [2:0] sink_o;
    logic [2:0] pwm_o;
    int lit [3]; // Lit cycles per LED
    int miscompares = 0;
    int total_checks = 0;
    integer seed = 32'h2309;
    logic [31:0] rd; // Last read data
    int code [3]; // Model current codes
    int duty [3]; // Model duty values
    int c0, n, rises;
    logic [15:0] m0, m1; // Levels seen
    logic [3:0] prev;
    always #4 clk_i = ~clk_i;
    led_flash_sequencer #(.STEP_CYC(STEP), .NCH(3)) led_flash_sequencer_i (
        .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .sink_o(sink_o), .pwm_o(pwm_o));
    led_load_model led_load_model_i (.clk_i(clk_i), .sink_i(sink_o), .pwm_i(pwm_o), .lit_o(lit));
    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task conclude;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One Avalon access, held until waitrequest low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= ~wr;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            miscompares++;
            conclude();
        end
        rd = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Wait for level on channel A, then count its cycles
    task span(input logic [3:0] lvl);
        n = 0;
        while (sink_o[0].level !== lvl && n < 300)
        begin
            @(posedge clk_i);
            n++;
        end
        c0 = 0;
        while (sink_o[0].level === lvl && n < 300)
        begin
            @(posedge clk_i);
            n++;
            c0++;
        end
        if (n >= 300)
        begin
            miscompares++;
            conclude();
        end
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, `OFS_CH_A, 0);
        check(rd, `CH_RESET);
        bus(0, `OFS_SLOT, 0);
        check(rd, {24'h0, `SLOT_RESET});
        bus(0, 8'h40, 0);
        check(rd, 32'h0);
        $display("test reset values done");
        // Steady drive with random codes, full, random and zero duty
        for (int k = 0; k < 3; k++)
        begin
            code[k] = 1 + ($unsigned($random(seed)) % 15);
            duty[k] = (k == 0) ? 31 : (k == 1) ? $unsigned($random(seed)) % 31 : 0;
            bus(1, `OFS_CH_A + 8'(4 * k), 32'(code[k] + duty[k] * 16));
        end
        bus(1, `OFS_PIN_SEL, 32'h7);
        bus(1, `OFS_SEQ_EN, 32'h7);
        repeat (2) @(posedge clk_i);
        for (int k = 0; k < 3; k++)
        begin
            check({26'h0, sink_o[k]}, {26'h0, 2'b11, 4'(code[k])});
            c0 = lit[k];
            repeat (62) @(posedge clk_i);
            check(32'(lit[k] - c0), 32'(2 * duty[k]));
        end
        bus(1, `OFS_SEQ_EN, 32'h5);
        repeat (2) @(posedge clk_i);
        check({29'h0, sink_o[2].sink_on, sink_o[1].sink_on, sink_o[0].sink_on}, 32'h5);
        bus(1, `OFS_PIN_SEL, 32'h0);
        repeat (2) @(posedge clk_i);
        check({29'h0, sink_o[2].led_mode, sink_o[1].led_mode, sink_o[0].led_mode}, 32'h0);
        bus(1, `OFS_PIN_SEL, 32'h7);
        $display("test steady drive done");
        // Flash on A (ramped) and B (jump), C steady; slot outlasts ramps
        bus(1, `OFS_SLOT, 32'h10);
        bus(1, `OFS_RAMP, 32'h0201);
        bus(0, `OFS_RAMP, 0);
        check(rd, 32'h0201);
        bus(1, `OFS_CH_A, 32'h0002_03F3);
        bus(1, `OFS_CH_B, 32'h0002_01F5);
        bus(1, `OFS_CH_C, 32'h0000_01F7);
        bus(1, `OFS_SEQ_EN, 32'h37);
        m0 = '0;
        m1 = '0;
        rises = 0;
        n = 0;
        prev = 4'h0;
        repeat (680)
        begin
            @(posedge clk_i);
            m0[sink_o[0].level] = 1'b1;
            m1[sink_o[1].level] = 1'b1;
            if (prev == 4'h0 && sink_o[0].level == 4'h1)
                rises++;
            prev = sink_o[0].level;
            if (sink_o[2] !== 6'h37)
                n++;
        end
        check({16'h0, m0}, 32'h000F);
        check({16'h0, m1}, 32'h0021);
        check(32'(n), 32'h0);
        check({31'h0, rises >= 10}, 32'h1);
        span(4'h0);
        span(4'h1);
        check(32'(c0), 32'(STEP));
        span(4'h3);
        span(4'h2);
        check(32'(c0), 32'(2 * STEP));
        bus(1, `OFS_SEQ_EN, 32'h7);
        repeat (100) @(posedge clk_i);
        check({26'h0, sink_o[0]}, 32'h33);
        bus(0, `OFS_STATUS, 0);
        check(rd, 32'h0070_1403);
        $display("test flash done");
        conclude();
    end
endmodule // led_flash_sequencer_tb
